// ==== rtl/lsumem_pkg.sv ====
package lsumem_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int LSUMEM_MAU_W = 8;
	localparam int LSUMEM_DATA_W = 32;
	localparam int LSUMEM_ADDR_W = 32;
	localparam int LSUMEM_LANE_SEL_W = 2;
	localparam int LSUMEM_WADDR_W = LSUMEM_ADDR_W - LSUMEM_LANE_SEL_W;
	localparam int LSUMEM_LANES = LSUMEM_DATA_W / LSUMEM_MAU_W;
	localparam int LSUMEM_OP_W = 3;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic LSUMEM_SELECT_N_RST = 1'h1;
	localparam logic LSUMEM_WRITE_N_RST = 1'h1;
	localparam logic [LSUMEM_LANES-1:0] LSUMEM_MASK_RST = 4'h0;
	localparam logic [LSUMEM_LANES-1:0] LSUMEM_MASK_ALL = 4'hf;
	localparam logic [LSUMEM_LANES-1:0] LSUMEM_MASK_HALF = 4'h3;
	localparam logic [LSUMEM_LANES-1:0] LSUMEM_MASK_BYTE = 4'h1;

	// ****************************************
	// operation codes
	// ****************************************
	typedef enum logic [LSUMEM_OP_W-1:0] {
		load_word_op = 3'h0,
		load_half_unsigned_op = 3'h1,
		load_byte_unsigned_op = 3'h2,
		store_word_op = 3'h4,
		store_half_op = 3'h5,
		store_byte_op = 3'h6
	} lsumem_op_t;

	typedef enum logic {
		LSUMEM_IDLE = 1'h0,
		LSUMEM_WAIT = 1'h1
	} lsumem_state_t;
endpackage

// ==== rtl/lsumem_lane_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lsumem_lane_if;
	import lsumem_pkg::*;
	lsumem_op_t op;
	logic [LSUMEM_LANE_SEL_W-1:0] low_addr;
	logic [LSUMEM_LANES-1:0] mask;
	logic [LSUMEM_DATA_W-1:0] wdata_in;
	logic [LSUMEM_DATA_W-1:0] wdata_lane;
	modport unit (input op, input low_addr, input wdata_in, output mask, output wdata_lane);
	modport user (output op, output low_addr, output wdata_in, input mask, input wdata_lane);
endinterface
`default_nettype wire

// ==== rtl/lsumem_lane_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsumem_lane_sel
	import lsumem_pkg::*;
(
	lsumem_lane_if.unit lane
);
	logic [LSUMEM_LANES-1:0] mask_d;
	logic [LSUMEM_DATA_W-1:0] data_d;

	always_comb
	begin
		mask_d = LSUMEM_MASK_ALL;
		data_d = lane.wdata_in;
		case (lane.op)
			load_half_unsigned_op, store_half_op:
			begin
				// upper dropped bit picks the halfword
				mask_d = lane.low_addr[1] ? (LSUMEM_MASK_HALF << 2) : LSUMEM_MASK_HALF; // see RQ14
				data_d = {2{lane.wdata_in[15:0]}};
			end
			load_byte_unsigned_op, store_byte_op:
			begin
				mask_d = LSUMEM_MASK_BYTE << lane.low_addr; // see RQ14
				data_d = {4{lane.wdata_in[7:0]}};
			end
			default:
			begin
				mask_d = LSUMEM_MASK_ALL; // see RQ13
				data_d = lane.wdata_in;
			end
		endcase
	end

	assign lane.mask = mask_d; // see RQ5
	assign lane.wdata_lane = data_d;
endmodule
`default_nettype wire

// ==== rtl/lsumem_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1 - memory returns read word in the command cycle; the port samples it in the command cycle itself
// RQ2 - memory read output is not registered
// RQ3 - byte units, 32-bit memory words
// RQ4 - word address drops two low bits
// RQ5 - lane mask from low bits and op
// RQ6 - mask is four bits, one per lane
// RQ7 - mask one enables lane, zero leaves it
// RQ8 - select low only during memory operations
// RQ9 - memory idles while select is high
// RQ10 - write low for store, high for load
// RQ11 - memory inverts write if active high
// RQ12 - data full width, address width minus two
// RQ13 - word ops whole, narrow ops use mask
// RQ14 - halfword by bit one, byte by both
module lsumem_port
	import lsumem_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire logic [LSUMEM_OP_W-1:0] req_op_i,
	input wire logic [LSUMEM_ADDR_W-1:0] req_addr_i,
	input wire logic [LSUMEM_DATA_W-1:0] req_wdata_i,
	output logic load_valid_o,
	output logic [LSUMEM_DATA_W-1:0] load_data_o,
	input wire logic [LSUMEM_DATA_W-1:0] mem_read_word_i,
	output logic [LSUMEM_DATA_W-1:0] mem_write_word_o,
	output logic [LSUMEM_WADDR_W-1:0] mem_word_address_o,
	output logic mem_select_n_o,
	output logic mem_write_n_o,
	output logic [LSUMEM_LANES-1:0] byte_lane_mask_o
);
	// ****************************************
	// lane selection
	// ****************************************
	lsumem_lane_if lane_bus();
	lsumem_op_t op_w;
	logic is_store_w;
	logic is_known_w;

	assign op_w = lsumem_op_t'(req_op_i);
	assign is_store_w = req_op_i[2];
	assign is_known_w = (op_w == load_word_op) || (op_w == load_half_unsigned_op) ||
		(op_w == load_byte_unsigned_op) || (op_w == store_word_op) ||
		(op_w == store_half_op) || (op_w == store_byte_op);
	assign lane_bus.op = op_w;
	assign lane_bus.low_addr = req_addr_i[LSUMEM_LANE_SEL_W-1:0];
	assign lane_bus.wdata_in = req_wdata_i;

	lsumem_lane_sel u_lane_sel (
		.lane(lane_bus)
	);

	// ****************************************
	// memory command
	// ****************************************
	logic mem_select_n_q;
	logic mem_write_n_q;
	logic [LSUMEM_WADDR_W-1:0] mem_word_address_q;
	logic [LSUMEM_DATA_W-1:0] mem_write_word_q;
	logic [LSUMEM_LANES-1:0] byte_lane_mask_q;
	logic fire_w;

	// unknown op codes issue nothing rather than a guessed access
	assign fire_w = req_valid_i && is_known_w;

	// select stands for exactly the one command cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mem_select_n_q <= LSUMEM_SELECT_N_RST;
		end
		else
		begin
			mem_select_n_q <= !fire_w; // see RQ8
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mem_write_n_q <= LSUMEM_WRITE_N_RST;
		end
		else
		begin
			// write idles high so a stray enable can never store
			mem_write_n_q <= !(fire_w && is_store_w); // see RQ10
		end
	end

	// address and data hold their last value between commands
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mem_word_address_q <= '0;
		end
		else if (fire_w)
		begin
			mem_word_address_q <= req_addr_i[LSUMEM_ADDR_W-1:LSUMEM_LANE_SEL_W]; // see RQ4
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mem_write_word_q <= '0;
		end
		else if (fire_w)
		begin
			mem_write_word_q <= lane_bus.wdata_lane; // see RQ12
		end
	end

	// an idle mask of zero keeps every lane shut between commands
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			byte_lane_mask_q <= LSUMEM_MASK_RST;
		end
		else if (fire_w)
		begin
			byte_lane_mask_q <= lane_bus.mask; // see RQ6
		end
		else
		begin
			byte_lane_mask_q <= LSUMEM_MASK_RST; // see RQ7
		end
	end

	// ****************************************
	// load return
	// ****************************************
	lsumem_state_t state_q;
	lsumem_op_t ld_op_q;
	logic [LSUMEM_LANE_SEL_W-1:0] ld_low_q;
	logic load_valid_q;
	logic [LSUMEM_DATA_W-1:0] load_data_q;
	logic [LSUMEM_DATA_W-1:0] shifted_w;
	logic [LSUMEM_DATA_W-1:0] half_shifted_w;
	logic fire_load_w;

	assign fire_load_w = fire_w && !is_store_w;

	// one wait state; back-to-back loads simply stay in it
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= LSUMEM_IDLE;
		end
		else if (fire_load_w)
		begin
			state_q <= LSUMEM_WAIT;
		end
		else
		begin
			state_q <= LSUMEM_IDLE;
		end
	end

	// width and lane position of the load in flight
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ld_op_q <= load_word_op;
			ld_low_q <= '0;
		end
		else if (fire_load_w)
		begin
			ld_op_q <= op_w;
			ld_low_q <= req_addr_i[LSUMEM_LANE_SEL_W-1:0];
		end
	end

	// word shows up on the read input in the command cycle itself, while select is low
	assign shifted_w = mem_read_word_i >> {ld_low_q, 3'h0}; // see RQ1
	// a halfword ignores the odd byte bit, just as its lane mask does
	assign half_shifted_w = mem_read_word_i >> {ld_low_q[1], 4'h0}; // see RQ14

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			load_valid_q <= 1'h0;
		end
		else
		begin
			case (state_q)
				LSUMEM_WAIT:
				begin
					load_valid_q <= 1'h1; // see RQ1
				end
				default:
				begin
					load_valid_q <= 1'h0;
				end
			endcase
		end
	end

	// load data holds until the next load returns
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			load_data_q <= '0;
		end
		else if (state_q == LSUMEM_WAIT)
		begin
			// captured here since the memory output is combinational
			case (ld_op_q)
				load_half_unsigned_op:
				begin
					load_data_q <= {16'h0, half_shifted_w[15:0]}; // see RQ13
				end
				load_byte_unsigned_op:
				begin
					load_data_q <= {24'h0, shifted_w[7:0]}; // see RQ3
				end
				default:
				begin
					load_data_q <= mem_read_word_i; // see RQ2
				end
			endcase
		end
	end

	assign mem_select_n_o = mem_select_n_q;
	assign mem_write_n_o = mem_write_n_q;
	assign mem_word_address_o = mem_word_address_q;
	assign mem_write_word_o = mem_write_word_q;
	assign byte_lane_mask_o = byte_lane_mask_q;
	assign load_valid_o = load_valid_q;
	assign load_data_o = load_data_q;
endmodule
`default_nettype wire

// ==== verification/lsumem_port_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsumem_port_checker (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire logic [2:0] req_op_i,
	input wire logic [31:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic load_valid_o,
	input wire logic [31:0] load_data_o,
	input wire logic [31:0] mem_read_word_i,
	input wire logic [31:0] mem_write_word_o,
	input wire logic [29:0] mem_word_address_o,
	input wire logic mem_select_n_o,
	input wire logic mem_write_n_o,
	input wire logic [3:0] byte_lane_mask_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic ok;
	// codes 3 and 7 are refused, so they must not start a command
	assign ok = req_valid_i && req_op_i[1:0] != 2'h3;
	sequence s_load;
		ok && !req_op_i[2] ##1 !mem_select_n_o && mem_write_n_o;
	endsequence
	sequence s_load_word;
		ok && req_op_i == 3'h0 ##1 !mem_select_n_o;
	endsequence
	property p_sel; ok |=> !mem_select_n_o; endproperty
	property p_idle; !ok |=> mem_select_n_o && mem_write_n_o && byte_lane_mask_o == 4'h0; endproperty
	property p_wr; ok |=> mem_write_n_o == !$past(req_op_i[2]); endproperty
	property p_addr; ok |=> mem_word_address_o == $past(req_addr_i[31:2]); endproperty
	property p_word; ok && req_op_i[1:0] == 2'h0 |=> byte_lane_mask_o == 4'hf; endproperty
	property p_half; ok && req_op_i[1:0] == 2'h1 |=> byte_lane_mask_o == ($past(req_addr_i[1]) ? 4'hc : 4'h3); endproperty
	property p_byte; ok && req_op_i[1:0] == 2'h2 |=> byte_lane_mask_o == 4'h1 << $past(req_addr_i[1:0]); endproperty
	property p_load; s_load |=> load_valid_o; endproperty
	property p_ldata; s_load_word |=> load_data_o == $past(mem_read_word_i); endproperty
	property p_wbyte; ok && req_op_i == 3'h6 |=> mem_write_word_o == {4{$past(req_wdata_i[7:0])}}; endproperty
	a_sel: assert property (p_sel) else $error("select missing");
	a_idle: assert property (p_idle) else $error("idle outputs wrong");
	a_wr: assert property (p_wr) else $error("write strobe wrong");
	a_addr: assert property (p_addr) else $error("word address wrong");
	a_word: assert property (p_word) else $error("word mask wrong");
	a_half: assert property (p_half) else $error("half mask wrong");
	a_byte: assert property (p_byte) else $error("byte mask wrong");
	a_load: assert property (p_load) else $error("load result missing");
	a_ldata: assert property (p_ldata) else $error("load data wrong");
	a_wbyte: assert property (p_wbyte) else $error("byte store data wrong");
endmodule
bind lsumem_port lsumem_port_checker lsumem_port_checker_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
	.load_valid_o(load_valid_o), .load_data_o(load_data_o), .mem_read_word_i(mem_read_word_i),
	.mem_write_word_o(mem_write_word_o), .mem_word_address_o(mem_word_address_o),
	.mem_select_n_o(mem_select_n_o), .mem_write_n_o(mem_write_n_o), .byte_lane_mask_o(byte_lane_mask_o));
`default_nettype wire

// ==== verification/lsumem_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsumem_mem_model (
	input wire logic clk_i,
	input wire logic sel_n_i,
	input wire logic wr_n_i,
	input wire logic [29:0] addr_i,
	input wire logic [3:0] mask_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [16];
	always_ff @(posedge clk_i)
	begin
		for (int k = 0; k < 4; k++)
		begin
			if (!sel_n_i && !wr_n_i && mask_i[k])
			begin
				mem[addr_i[3:0]][8*k +: 8] <= wdata_i[8*k +: 8];
			end
		end
	end
	// unregistered read; garbage while unselected so a late sample cannot pass
	assign rdata_o = sel_n_i ? ~mem[addr_i[3:0]] : mem[addr_i[3:0]];
endmodule
`default_nettype wire

// ==== verification/lsumem_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsumem_port_test;
	import lsumem_pkg::*;
	typedef struct {logic [2:0] op; logic [31:0] a; logic [31:0] d; logic [3:0] m; logic [31:0] r;} lsumem_row_t;
	logic clk = 0, rst_n = 0, v = 0, lv, sn, wn;
	logic [2:0] op = '0;
	logic [31:0] a = '0, d = '0, ld, rw, ww;
	logic [29:0] wa;
	logic [3:0] mk;
	int errors = 0, num_checks = 0;
	// r is the load result for loads and the lane-replicated write word for stores
	lsumem_row_t rows [7] = '{'{store_word_op, 32'h10, 32'h11223344, 4'hf, 32'h11223344},
		'{store_byte_op, 32'h13, 32'ha5, 4'h8, 32'ha5a5a5a5}, '{store_half_op, 32'h10, 32'hbeef, 4'h3, 32'hbeefbeef},
		'{load_word_op, 32'h10, 32'h0, 4'hf, 32'ha522beef}, '{load_half_unsigned_op, 32'h12, 32'h0, 4'hc, 32'ha522},
		'{load_byte_unsigned_op, 32'h11, 32'h0, 4'h2, 32'hbe},
		'{load_half_unsigned_op, 32'h13, 32'h0, 4'hc, 32'ha522}};
	always #12.5 clk = ~clk;
	lsumem_port lsumem_port_i (.sys_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(v), .req_op_i(op), .req_addr_i(a),
		.req_wdata_i(d), .load_valid_o(lv), .load_data_o(ld), .mem_read_word_i(rw), .mem_write_word_o(ww),
		.mem_word_address_o(wa), .mem_select_n_o(sn), .mem_write_n_o(wn), .byte_lane_mask_o(mk));
	lsumem_mem_model lsumem_mem_model_i (.clk_i(clk), .sel_n_i(sn), .wr_n_i(wn), .addr_i(wa), .mask_i(mk),
		.wdata_i(ww), .rdata_o(rw));
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic run(input lsumem_row_t r);
		op = r.op;
		a = r.a;
		d = r.d;
		v = 1;
		@(negedge clk);
		v = 0;
		chk(33'({sn, wn, mk}), 33'({1'b0, !r.op[2], r.m}));
		chk(33'(wa), 33'(r.a[31:2]));
		if (r.op[2])
			chk(33'(ww), 33'(r.r));
		@(negedge clk);
		if (!r.op[2])
			chk({lv, ld}, {1'b1, r.r});
		else
			chk(33'(lv), 33'h0);
		$display("test op=%h addr=%h done", r.op, r.a);
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		chk(33'({sn, wn, mk}), 33'h30);
		rst_n = 1;
		foreach (rows[i])
			run(rows[i]);
		// store, load of the same word and a refused code, back to back
		op = store_word_op;
		a = 32'h20;
		d = 32'h0badcafe;
		v = 1;
		@(negedge clk);
		op = load_word_op;
		chk(33'(wn), 33'h0);
		@(negedge clk);
		op = 3'h3;
		@(negedge clk);
		v = 0;
		chk({lv, ld}, {1'b1, 32'h0badcafe});
		chk(33'({sn, mk}), 33'h10);
		$display("test back to back done");
		// reset with a load in flight: its result must never appear
		@(negedge clk);
		op = load_word_op;
		a = 32'h10;
		v = 1;
		@(negedge clk);
		v = 0;
		rst_n = 0;
		@(negedge clk);
		chk(33'({sn, wn, mk, lv}), 33'h60);
		chk({lv, ld}, 33'h0);
		rst_n = 1;
		@(negedge clk);
		chk({lv, ld}, 33'h0);
		chk(33'({sn, wn, mk}), 33'h30);
		run(rows[3]);
		$display("test reset done");
		final_report();
	end
endmodule
`default_nettype wire
